// ==== rtl/anl_pkg.sv ====
// Purpose: Shared constants for the node-list and mode record service
// Assumes: One clock, synchronous active-high reset
// Notes: Byte positions refer to the record payload
package anl_pkg;
  localparam logic [7:0] IDX_PROJ = 8'h0D;
  localparam logic [7:0] IDX_ACT = 8'h0E;
  localparam logic [7:0] IDX_DET = 8'h0F;
  localparam logic [7:0] IDX_FLAGS = 8'h10;
  localparam logic [7:0] IDX_OPMODE = 8'h11;
  localparam logic [7:0] IDX_OFFLINE = 8'h12;
  localparam logic [7:0] SLOT_SEG1 = 8'h00;
  localparam logic [7:0] SLOT_SEG2 = 8'h64;
  localparam logic [7:0] SUBSLOT_REC = 8'h01;
  localparam logic [3:0] LIST_LEN = 4'hC;
  localparam logic [3:0] FLAGS_LEN = 4'h4;
  localparam logic [3:0] BYTE_LIST0 = 4'h2;
  localparam logic [3:0] BYTE_STATUS = 4'hB;
  localparam logic [3:0] BYTE_FLAGS0 = 4'h2;
  localparam logic [3:0] BYTE_FLAGS1 = 4'h3;
  localparam logic [3:0] BYTE_LIST_B0 = 4'h6;
  localparam logic [3:0] BYTE_UNUSED = 4'hA;
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] STAT_NOK = 8'h01;
  localparam logic [1:0] INT_DONE = 2'h0;
  localparam logic [1:0] INT_ERR = 2'h1;
  localparam logic [1:0] INT_MODE = 2'h2;
  // Software registers for interrupts and the mode readback
  localparam logic [3:0] REG_IRQ_STAT = 4'h0;
  localparam logic [3:0] REG_IRQ_MASK = 4'h4;
  localparam logic [3:0] REG_MODES = 4'h8;
  typedef enum logic [1:0] {
    ANL_IDLE = 2'b00,
    ANL_SEND = 2'b01,
    ANL_WAIT = 2'b10
  } anl_state_t;
endpackage : anl_pkg

// ==== rtl/anl_resp_if.sv ====
// Purpose: Response byte memory port bundle
// Assumes: Single clock
// Notes: Writer fills, reader fetches one byte a cycle
`timescale 1ns/1ns
interface anl_resp_if;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;
  logic [3:0] rd_addr;
  logic [7:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data,
    output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
    input rd_addr, output rd_data);
endinterface : anl_resp_if

// ==== rtl/anl_resp_mem.sv ====
// Purpose: Sixteen-byte response buffer with registered read
// Assumes: Single clock
// Notes: Read data stand one cycle after the address
`timescale 1ns/1ns
module anl_resp_mem (
  input wire logic clk,
  anl_resp_if.mem bus
);
  logic [7:0] mem_ff [16];
  logic [7:0] rd_ff;
  always_ff @(posedge clk) begin
    if (bus.wr_en) begin
      mem_ff[bus.wr_addr] <= bus.wr_data;
    end
  end
  always_ff @(posedge clk) begin
    rd_ff <= mem_ff[bus.rd_addr];
  end
  assign bus.rd_data = rd_ff;
endmodule : anl_resp_mem

// ==== rtl/anl_node_records.sv ====
// Purpose: Record interpreter for node lists, flags and mode writes
// Assumes: Requests are single-cycle strobes with slot, subslot, index
// Notes: Response bytes are streamed out one per cycle after a request
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module anl_node_records
  import anl_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic REQ_RD,
  input wire logic REQ_WR,
  input wire logic [7:0] REQ_SLOT,
  input wire logic [7:0] REQ_SUBSLOT,
  input wire logic [7:0] REQ_INDEX,
  input wire logic [7:0] REQ_CMD,
  input wire logic [63:0] SEG1_PROJECTED,
  input wire logic [63:0] SEG1_ACTIVATED,
  input wire logic [63:0] SEG1_DETECTED,
  input wire logic [63:0] SEG2_PROJECTED,
  input wire logic [63:0] SEG2_ACTIVATED,
  input wire logic [63:0] SEG2_DETECTED,
  input wire logic [7:0] SEG1_FLAGS,
  input wire logic [7:0] SEG2_FLAGS,
  input wire logic [1:0] SEG1_FLAGS_HI,
  input wire logic [1:0] SEG2_FLAGS_HI,
  input wire logic [1:0] MODE_ACK_OK,
  output logic REQ_BUSY,
  output logic RESP_VALID,
  output logic RESP_LAST,
  output logic [7:0] RESP_DATA,
  output logic WR_DONE,
  output logic [7:0] WR_STATUS,
  output logic [1:0] CONFIG_MODE,
  output logic [1:0] OFFLINE_MODE,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic IRQ
);
  ////////////////////////////////////////////////////////////////////////
  // Node list is 64 bits: bit n is node n (A), bit 32+n is node nB.
  function automatic logic [7:0] list_byte(input logic [63:0] lst,
                                           input logic [3:0] b);
    logic [5:0] base;
    logic [7:0] r;
    base = 6'(({2'b00, b} - {2'b00, BYTE_LIST0}) * 6'd8);
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = lst[6'(base + 6'(i))];
    end
    if (b == BYTE_LIST0) begin
      r[0] = 1'b0;
    end
    // Bit 0 of the first B byte would be node 0B, which has no slot
    if (b == BYTE_LIST_B0) begin
      r[0] = 1'b0;
    end
    return r;
  endfunction : list_byte

  // Remap: bytes 2..5 A nodes 0..31, bytes 6..9 B nodes 0..31
  function automatic logic [63:0] pick(input logic seg,
                                       input logic [63:0] a,
                                       input logic [63:0] b);
    return seg ? b : a;
  endfunction : pick

  // One screen for reads and writes alike
  function automatic logic addr_ok(input logic [7:0] slot,
                                   input logic [7:0] sub);
    return ((slot == SLOT_SEG1) || (slot == SLOT_SEG2)) &&
      (sub == SUBSLOT_REC);
  endfunction : addr_ok

  ////////////////////////////////////////////////////////////////////////
  anl_resp_if rif ();
  anl_resp_mem u_mem (
    .clk(CLOCK),
    .bus(rif)
  );

  anl_state_t state_ff;
  anl_state_t nxt_state;
  logic seg_ff;
  logic [7:0] idx_ff;
  logic ok_ff;
  logic [3:0] fill_ff;
  logic [3:0] len_ff;
  logic [3:0] rd_ptr_ff;
  logic vld_ff;
  logic last_ff;
  logic [7:0] data_ff;
  logic [1:0] cfg_ff;
  logic [1:0] off_ff;
  logic done_ff;
  logic [7:0] wst_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic [31:0] rdata_ff;
  logic [63:0] cur_list;
  logic [7:0] fill_byte;
  logic is_list;
  logic is_flags;
  logic rd_ok;
  logic wr_ok;
  logic wr_seg;
  logic [2:0] ev;

  // Other slots fall to segment one; addr_ok refuses them anyway
  assign wr_seg = (REQ_SLOT == SLOT_SEG2);
  assign rd_ok = addr_ok(REQ_SLOT, REQ_SUBSLOT) &&
    (((REQ_INDEX >= IDX_PROJ) && (REQ_INDEX <= IDX_FLAGS)));
  assign wr_ok = addr_ok(REQ_SLOT, REQ_SUBSLOT) &&
    ((REQ_INDEX == IDX_OPMODE) || (REQ_INDEX == IDX_OFFLINE));
  assign is_list = (idx_ff != IDX_FLAGS);
  assign is_flags = (idx_ff == IDX_FLAGS);

  ////////////////////////////////////////////////////////////////////////
  // Request sequencer
  // Bad reads still run a full fill so the status lands last
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ANL_IDLE: begin
        if (REQ_RD) begin
          nxt_state = ANL_WAIT;
        end
      end
      ANL_WAIT: begin
        if (fill_ff == len_ff - 4'h1) begin
          nxt_state = ANL_SEND;
        end
      end
      ANL_SEND: begin
        if (rd_ptr_ff == len_ff) begin
          nxt_state = ANL_IDLE;
        end
      end
      default: nxt_state = ANL_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_ff <= ANL_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      seg_ff <= 1'b0;
      idx_ff <= 8'h00;
      ok_ff <= 1'b0;
      len_ff <= 4'h0;
    end else if (state_ff == ANL_IDLE && REQ_RD) begin
      seg_ff <= (REQ_SLOT == SLOT_SEG2);
      idx_ff <= REQ_INDEX;
      ok_ff <= rd_ok;
      len_ff <= (REQ_INDEX == IDX_FLAGS) ? FLAGS_LEN : LIST_LEN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Response image build, one byte per cycle into the buffer
  always_comb begin
    case (idx_ff)
      IDX_PROJ: cur_list = pick(seg_ff, SEG1_PROJECTED,
                                SEG2_PROJECTED);
      IDX_ACT: cur_list = pick(seg_ff, SEG1_ACTIVATED,
                               SEG2_ACTIVATED);
      IDX_DET: cur_list = pick(seg_ff, SEG1_DETECTED,
                               SEG2_DETECTED);
      default: cur_list = 64'h0;
    endcase
  end

  always_comb begin
    fill_byte = 8'h00;
    if (!ok_ff) begin
      fill_byte = (fill_ff == len_ff - 4'h1) ? STAT_NOK : 8'h00;
    end else if (is_list) begin
      if (fill_ff >= BYTE_LIST0 && fill_ff < BYTE_UNUSED) begin
        fill_byte = list_byte(cur_list, fill_ff);
      end else if (fill_ff == BYTE_UNUSED) begin
        fill_byte = 8'h00;
      end else if (fill_ff == BYTE_STATUS) begin
        fill_byte = STAT_OK;
      end
    end else if (is_flags) begin
      if (fill_ff == BYTE_FLAGS0) begin
        fill_byte = seg_ff ? SEG2_FLAGS : SEG1_FLAGS;
      end else if (fill_ff == BYTE_FLAGS1) begin
        fill_byte = {5'h00, off_ff[seg_ff],
          seg_ff ? SEG2_FLAGS_HI : SEG1_FLAGS_HI};
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      fill_ff <= 4'h0;
    end else if (state_ff == ANL_WAIT) begin
      fill_ff <= fill_ff + 4'h1;
    end else begin
      fill_ff <= 4'h0;
    end
  end

  assign rif.wr_en = (state_ff == ANL_WAIT);
  assign rif.wr_addr = fill_ff;
  assign rif.wr_data = fill_byte;
  assign rif.rd_addr = rd_ptr_ff;

  ////////////////////////////////////////////////////////////////////////
  // Response stream out
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rd_ptr_ff <= 4'h0;
    end else if (state_ff == ANL_SEND && rd_ptr_ff != len_ff) begin
      rd_ptr_ff <= rd_ptr_ff + 4'h1;
    end else if (state_ff != ANL_SEND) begin
      rd_ptr_ff <= 4'h0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      vld_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      vld_ff <= (state_ff == ANL_SEND) && (rd_ptr_ff != len_ff);
      last_ff <= (state_ff == ANL_SEND) && (rd_ptr_ff == len_ff - 4'h1);
    end
  end

  assign RESP_VALID = vld_ff;
  assign RESP_LAST = last_ff;
  assign RESP_DATA = vld_ff ? rif.rd_data : 8'h00;
  // Busy covers the last byte so a new read cannot overwrite it
  assign REQ_BUSY = (state_ff != ANL_IDLE) || vld_ff;

  ////////////////////////////////////////////////////////////////////////
  // Mode commands
  // Writes during a read are dropped, not queued
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cfg_ff <= 2'b00;
      off_ff <= 2'b00;
    end else if (REQ_WR && !REQ_BUSY && wr_ok &&
                 MODE_ACK_OK[wr_seg]) begin
      if (REQ_INDEX == IDX_OPMODE) begin
        cfg_ff[wr_seg] <= REQ_CMD[0];
      end else begin
        off_ff[wr_seg] <= REQ_CMD[0];
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      done_ff <= 1'b0;
      wst_ff <= STAT_OK;
    end else begin
      done_ff <= REQ_WR && !REQ_BUSY;
      if (REQ_WR && !REQ_BUSY) begin
        wst_ff <= (wr_ok && MODE_ACK_OK[wr_seg]) ? STAT_OK
          : STAT_NOK;
      end
    end
  end

  assign WR_DONE = done_ff;
  assign WR_STATUS = wst_ff;
  assign CONFIG_MODE = cfg_ff;
  assign OFFLINE_MODE = off_ff;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, mask and register port
  // Done also marks the last read byte, so polling is optional
  assign ev[INT_DONE] = last_ff || (done_ff && wst_ff == STAT_OK);
  assign ev[INT_ERR] = done_ff && wst_ff != STAT_OK;
  assign ev[INT_MODE] = done_ff && wst_ff == STAT_OK;

  // Set wins over a clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      irq_stat_ff <= 3'h0;
    end else if (REG_WR && REG_ADDR == REG_IRQ_STAT) begin
      irq_stat_ff <= (irq_stat_ff & ~REG_WDATA[2:0]) | ev;
    end else begin
      irq_stat_ff <= irq_stat_ff | ev;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      irq_mask_ff <= 3'h0;
    end else if (REG_WR && REG_ADDR == REG_IRQ_MASK) begin
      irq_mask_ff <= REG_WDATA[2:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_ff <= 32'h0;
    end else if (REG_RD) begin
      case (REG_ADDR)
        REG_IRQ_STAT: rdata_ff <= {29'h0, irq_stat_ff};
        REG_IRQ_MASK: rdata_ff <= {29'h0, irq_mask_ff};
        REG_MODES: rdata_ff <= {28'h0, off_ff, cfg_ff};
        default: rdata_ff <= 32'h0;
      endcase
    end else begin
      // Read data stand for one cycle only
      rdata_ff <= 32'h0;
    end
  end

  assign REG_RDATA = rdata_ff;
  assign IRQ = |(irq_stat_ff & irq_mask_ff);
endmodule : anl_node_records

// ==== testbench/anl_node_records_props.sv ====
// Purpose: Concurrent checks on the record interpreter ports
// Assumes: One clock, synchronous active-high reset
// Notes: Mode writes checked for segment one operating mode and segment two offline mode, address refusals keep both modes, ack-low ones keep CONFIG_MODE
`timescale 1ns/1ns
module anl_node_records_props
  import anl_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic REQ_RD,
  input wire logic REQ_WR,
  input wire logic [7:0] REQ_SLOT,
  input wire logic [7:0] REQ_SUBSLOT,
  input wire logic [7:0] REQ_INDEX,
  input wire logic [7:0] REQ_CMD,
  input wire logic [1:0] MODE_ACK_OK,
  input wire logic REQ_BUSY,
  input wire logic RESP_VALID,
  input wire logic RESP_LAST,
  input wire logic [7:0] RESP_DATA,
  input wire logic WR_DONE,
  input wire logic [7:0] WR_STATUS,
  input wire logic [1:0] CONFIG_MODE,
  input wire logic [1:0] OFFLINE_MODE
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  logic addr_ok;
  assign addr_ok = (REQ_SLOT == SLOT_SEG1 || REQ_SLOT == SLOT_SEG2) &&
    REQ_SUBSLOT == SUBSLOT_REC;
  sequence rd_take;
    REQ_RD && !REQ_BUSY;
  endsequence
  sequence wr_take;
    REQ_WR && !REQ_BUSY;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  read_answer_a: assert property (rd_take |-> ##[3:16] RESP_VALID)
    else $error("read got no response bytes");
  wr_done_a: assert property (wr_take |=> WR_DONE)
    else $error("write not completed next cycle");
  done_cause_a: assert property (WR_DONE |->
    $past(REQ_WR && !REQ_BUSY))
    else $error("write done without a write");
  bad_addr_a: assert property (wr_take ##0 !addr_ok |=>
    WR_STATUS == STAT_NOK && $stable(CONFIG_MODE) && $stable(OFFLINE_MODE))
    else $error("bad slot or subslot not refused");
  cfg_write_a: assert property (wr_take ##0 (REQ_SLOT == SLOT_SEG1 &&
    REQ_SUBSLOT == SUBSLOT_REC && REQ_INDEX == IDX_OPMODE && MODE_ACK_OK[0])
    |=> WR_STATUS == STAT_OK && CONFIG_MODE[0] == $past(REQ_CMD[0]))
    else $error("operating mode write wrong");
  off_write_a: assert property (wr_take ##0 (REQ_SLOT == SLOT_SEG2 &&
    REQ_SUBSLOT == SUBSLOT_REC && REQ_INDEX == IDX_OFFLINE && MODE_ACK_OK[1])
    |=> WR_STATUS == STAT_OK && OFFLINE_MODE[1] == $past(REQ_CMD[0]))
    else $error("offline write wrong");
  ack_low_a: assert property (wr_take ##0 MODE_ACK_OK == 2'h0 |=>
    WR_STATUS == STAT_NOK && $stable(CONFIG_MODE))
    else $error("rejected mode command reported OK");
  last_valid_a: assert property (RESP_LAST |-> RESP_VALID)
    else $error("last flag outside a byte");
  idle_zero_a: assert property (!RESP_VALID |-> RESP_DATA == 8'h00)
    else $error("response data while not valid");
endmodule : anl_node_records_props
bind anl_node_records anl_node_records_props anl_node_records_props_inst (
  .CLOCK(CLOCK), .RST(RST), .REQ_RD(REQ_RD), .REQ_WR(REQ_WR),
  .REQ_SLOT(REQ_SLOT), .REQ_SUBSLOT(REQ_SUBSLOT), .REQ_INDEX(REQ_INDEX),
  .REQ_CMD(REQ_CMD), .MODE_ACK_OK(MODE_ACK_OK), .REQ_BUSY(REQ_BUSY),
  .RESP_VALID(RESP_VALID), .RESP_LAST(RESP_LAST), .RESP_DATA(RESP_DATA),
  .WR_DONE(WR_DONE), .WR_STATUS(WR_STATUS), .CONFIG_MODE(CONFIG_MODE),
  .OFFLINE_MODE(OFFLINE_MODE));

// ==== testbench/anl_ctl_model.sv ====
// Purpose: Fieldbus controller issuing record requests
// Assumes: Caller waits for idle before a read
// Notes: Request held one cycle, then fields are scrambled
`timescale 1ns/1ns
module anl_ctl_model
  import anl_pkg::*;
(
  input wire logic CLOCK,
  output logic REQ_RD,
  output logic REQ_WR,
  output logic [7:0] REQ_SLOT,
  output logic [7:0] REQ_SUBSLOT,
  output logic [7:0] REQ_INDEX,
  output logic [7:0] REQ_CMD
);
  initial begin
    REQ_RD = 1'b0;
    REQ_WR = 1'b0;
    REQ_SLOT = 8'hFF;
    REQ_SUBSLOT = 8'hFF;
    REQ_INDEX = 8'hFF;
    REQ_CMD = 8'hFF;
  end
  task automatic send(input logic rd, input logic [7:0] sl, sb, ix, cm);
    @(posedge CLOCK);
    REQ_RD <= rd;
    REQ_WR <= !rd;
    REQ_SLOT <= sl;
    REQ_SUBSLOT <= sb;
    REQ_INDEX <= ix;
    REQ_CMD <= cm;
    @(posedge CLOCK);
    REQ_RD <= 1'b0;
    REQ_WR <= 1'b0;
    // Stale fields flipped so a late sample cannot pass
    REQ_SLOT <= ~sl;
    REQ_SUBSLOT <= ~sb;
    REQ_INDEX <= ~ix;
    REQ_CMD <= ~cm;
  endtask : send
endmodule : anl_ctl_model

// ==== testbench/anl_node_records_bench.sv ====
// Purpose: Self-checking bench for the record interpreter
// Assumes: 10 MHz clock, reset held 12 cycles
// Notes: Byte 10 of list records is unused and not compared
`timescale 1ns/1ns
module anl_node_records_bench
  import anl_pkg::*;
;
  logic CLOCK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
  logic [3:0] REG_ADDR = 4'h0;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, rv;
  logic [1:0] MODE_ACK_OK = 2'h3, CONFIG_MODE, OFFLINE_MODE;
  logic [1:0] exp_cfg = 2'h0, exp_off = 2'h0;
  logic REQ_RD, REQ_WR, REQ_BUSY, RESP_VALID, RESP_LAST, WR_DONE, IRQ;
  logic [7:0] REQ_SLOT, REQ_SUBSLOT, REQ_INDEX, REQ_CMD, RESP_DATA, WR_STATUS;
  logic [63:0] lst [6] = '{64'h0123456789ABCDEF, 64'hFEDCBA9876543211,
    64'h8001C003E007F00F, 64'h5A5A5A5AA5A5A5A5, 64'h0F0F0F0FF0F0F0F1,
    64'hFFFFFFFF00000001};
  logic [7:0] flg [2] = '{8'hA5, 8'h3C};
  logic [1:0] hi [2] = '{2'h1, 2'h2};
  logic [7:0] q [$];
  int err_total = 0, checked = 0;
  always #50 CLOCK = ~CLOCK;
  anl_ctl_model anl_ctl_model_inst (.CLOCK(CLOCK), .REQ_RD(REQ_RD),
    .REQ_WR(REQ_WR), .REQ_SLOT(REQ_SLOT), .REQ_SUBSLOT(REQ_SUBSLOT),
    .REQ_INDEX(REQ_INDEX), .REQ_CMD(REQ_CMD));
  anl_node_records anl_node_records_inst (.CLOCK(CLOCK), .RST(RST),
    .REQ_RD(REQ_RD), .REQ_WR(REQ_WR), .REQ_SLOT(REQ_SLOT),
    .REQ_SUBSLOT(REQ_SUBSLOT), .REQ_INDEX(REQ_INDEX), .REQ_CMD(REQ_CMD),
    .SEG1_PROJECTED(lst[0]), .SEG1_ACTIVATED(lst[1]), .SEG1_DETECTED(lst[2]),
    .SEG2_PROJECTED(lst[3]), .SEG2_ACTIVATED(lst[4]), .SEG2_DETECTED(lst[5]),
    .SEG1_FLAGS(flg[0]), .SEG2_FLAGS(flg[1]), .SEG1_FLAGS_HI(hi[0]),
    .SEG2_FLAGS_HI(hi[1]), .MODE_ACK_OK(MODE_ACK_OK), .REQ_BUSY(REQ_BUSY),
    .RESP_VALID(RESP_VALID), .RESP_LAST(RESP_LAST), .RESP_DATA(RESP_DATA),
    .WR_DONE(WR_DONE), .WR_STATUS(WR_STATUS), .CONFIG_MODE(CONFIG_MODE),
    .OFFLINE_MODE(OFFLINE_MODE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
    #1;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a);
    @(posedge CLOCK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1;
    rv = REG_RDATA;
  endtask : reg_rd
  task automatic read_rec(input logic [7:0] sl, sb, ix);
    int i;
    logic got_last;
    for (i = 0; i < 50 && REQ_BUSY !== 1'b0; i++) begin
      @(posedge CLOCK);
      #1;
    end
    if (REQ_BUSY !== 1'b0) begin
      err_total++;
      end_sim();
    end
    q.delete();
    got_last = 1'b0;
    anl_ctl_model_inst.send(1'b1, sl, sb, ix, 8'h00);
    for (i = 0; i < 40 && !got_last; i++) begin
      @(posedge CLOCK);
      #1;
      if (RESP_VALID === 1'b1) begin
        q.push_back(RESP_DATA);
      end
      got_last = (RESP_LAST === 1'b1);
    end
    if (!got_last) begin
      err_total++;
      end_sim();
    end
  endtask : read_rec
  // Node bit 0 of each half-list has no place in the record
  function automatic logic [7:0] exp_byte(input logic [63:0] l, input int k);
    exp_byte = (k < 2 || k > 9) ? 8'h00 :
      l[8*(k-2) +: 8] & ((k == 2 || k == 6) ? 8'hFE : 8'hFF);
  endfunction : exp_byte
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge CLOCK);
    err_total++;
    end_sim();
  end
  initial begin
    int s, k, i;
    logic [7:0] sl, ix;
    logic c;
    repeat (12) @(posedge CLOCK);
    RST <= 1'b0;
    for (s = 0; s < 2; s++) begin
      sl = (s == 1) ? SLOT_SEG2 : SLOT_SEG1;
      for (k = 0; k < 3; k++) begin
        read_rec(sl, SUBSLOT_REC, 8'(IDX_PROJ + k));
        chk(q.size(), LIST_LEN);
        for (i = 0; i < 12; i++) begin
          if (i == 11) begin
            chk(q[i], STAT_OK);
          end else if (i != 10) begin
            chk(q[i], exp_byte(lst[3*s+k], i));
          end
        end
      end
      for (k = 0; k < 2; k++) begin
        ix = (k == 1) ? IDX_OFFLINE : IDX_OPMODE;
        for (i = 0; i < 3; i++) begin
          c = (i != 1);
          anl_ctl_model_inst.send(1'b0, sl, SUBSLOT_REC, ix, {7'h0, c});
          if (k == 1) exp_off[s] = c;
          else exp_cfg[s] = c;
          #1;
          chk(WR_DONE, 1'b1);
          chk(WR_STATUS, STAT_OK);
          chk({OFFLINE_MODE, CONFIG_MODE}, {exp_off, exp_cfg});
        end
      end
      read_rec(sl, SUBSLOT_REC, IDX_FLAGS);
      chk(q.size(), FLAGS_LEN);
      chk({q[0], q[1], q[2]}, {16'h0, flg[s]});
      chk(q[3], {5'h0, exp_off[s], hi[s]});
    end
    for (i = 0; i < 3; i++) begin
      @(posedge CLOCK);
      MODE_ACK_OK <= (i == 0) ? 2'h0 : 2'h3;
      anl_ctl_model_inst.send(1'b0, (i == 1) ? 8'h05 : SLOT_SEG1,
        (i == 2) ? 8'h02 : SUBSLOT_REC, IDX_OPMODE, 8'h00);
      #1;
      chk(WR_STATUS, STAT_NOK);
      chk({OFFLINE_MODE, CONFIG_MODE}, {exp_off, exp_cfg});
    end
    read_rec(8'h05, SUBSLOT_REC, IDX_PROJ);
    chk({q[2], q[9], q[11]}, {16'h0, STAT_NOK});
    reg_rd(REG_IRQ_STAT);
    chk(rv, 32'h7);
    reg_wr(REG_IRQ_MASK, 32'h0);
    chk(IRQ, 1'b0);
    reg_wr(REG_IRQ_MASK, 32'h2);
    chk(IRQ, 1'b1);
    reg_wr(REG_IRQ_STAT, 32'h2);
    chk(IRQ, 1'b0);
    reg_rd(REG_IRQ_STAT);
    chk(rv, 32'h5);
    reg_rd(REG_MODES);
    chk(rv, {28'h0, exp_off, exp_cfg});
    reg_rd(4'hC);
    chk(rv, 32'h0);
    end_sim();
  end
endmodule : anl_node_records_bench
